//--- pkg/pdmc_pkg.sv
// Package with register map, field positions, reset values and modes of the power-down mode controller.
package pdmc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] REG1_IDX   = 16'hFFF0;
  localparam logic [15:0] REG2_IDX   = 16'hFFF1;
  localparam int          ADR_W      = 18;
  localparam logic [17:0] REG1_ADR   = {REG1_IDX, 2'h0};
  localparam logic [17:0] REG2_ADR   = {REG2_IDX, 2'h0};

  // Reset values of the two control registers.
  localparam logic [7:0]  REG1_RESET = 8'h07;
  localparam logic [7:0]  REG2_RESET = 8'hE0;

  // Field positions in the first register.
  localparam int          STBY_POS   = 7;
  localparam int          WAIT_HI    = 6;
  localparam int          WAIT_LO    = 4;
  localparam int          LSPD_POS   = 3;
  localparam logic [2:0]  REG1_RSVD  = 3'h7;

  // Field positions in the second register.
  localparam int          NSEL_POS   = 4;
  localparam int          DTR_POS    = 3;
  localparam int          MSPD_POS   = 2;
  localparam int          SDIV_HI    = 1;
  localparam int          SDIV_LO    = 0;
  localparam logic [2:0]  REG2_RSVD  = 3'h7;

  // Clock-settling wait, in states of the system clock, for wait code zero.
  localparam int          SETTLE_BASE_STATES = 8192;
  localparam int          SETTLE_W           = 18;

  // Divide ratios of the subactive CPU clock and of the watch clock sampling.
  localparam logic [3:0]  SUB_DIV_8  = 4'h8;
  localparam logic [3:0]  SUB_DIV_4  = 4'h4;
  localparam logic [3:0]  SUB_DIV_2  = 4'h2;
  localparam logic [4:0]  NOISE_16   = 5'h10;
  localparam logic [4:0]  NOISE_4    = 5'h04;

  // Operating modes, Gray coded along the usual path.
  typedef enum logic [2:0] {
    M_ACT_HI   = 3'h0,
    M_SLEEP    = 3'h1,
    M_STANDBY  = 3'h3,
    M_SETTLE   = 3'h2,
    M_WATCH    = 3'h6,
    M_SUBACT   = 3'h7,
    M_SUBSLEEP = 3'h5,
    M_ACT_MED  = 3'h4
  } pdmc_mode_t;

endpackage : pdmc_pkg

//--- logic/pdmc_pin_sync.sv
// Three-stage synchroniser for a pin, with a level that changes once the last two stages agree.
`timescale 1ns/1ps
module pdmc_pin_sync #(
  parameter logic IDLE = 1'b1
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and filtered level.
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1;
  logic s2;
  logic s3;

  // Stage s1 feeds only s2, so a metastable value never reaches logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1      <= IDLE;
      s2      <= IDLE;
      s3      <= IDLE;
      level_o <= IDLE;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end

endmodule : pdmc_pin_sync

//--- logic/pdmc_settle_timer.sv
// Down-counter that times the oscillator settling wait in system clock cycles.
`timescale 1ns/1ps
module pdmc_settle_timer #(
  parameter int W = 18
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Load and completion.
  input  wire logic         load_i,
  input  wire logic [W-1:0] cycles_i,
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] count;

  initial begin
    if (W < 2) begin
      $error("Settle timer width too small");
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && (count == W'(1)) && !load_i;
      if (load_i) begin
        count <= cycles_i;
      end else if (busy_o) begin
        count <= count - W'(1);
      end
    end
  end

  assign busy_o = (count != '0);

endmodule : pdmc_settle_timer

//--- logic/pdmc_top.sv
// Power-down mode controller: control registers, SLEEP mode decision, wakeup and clock gating.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module pdmc_top #(
  parameter int          IRQ_N        = 8,
  parameter logic [7:0]  DEEP_WAKE    = 8'h0F,
  parameter int          SETTLE_BASE  = pdmc_pkg::SETTLE_BASE_STATES
) (
  // Clock and reset.
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave.
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [17:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // CPU core and interrupt controller.
  input  wire logic               sleep_exec_i,
  input  wire logic               timer_watch_select_i,
  input  wire logic [IRQ_N-1:0]   irq_req_i,
  input  wire logic [IRQ_N-1:0]   irq_en_i,
  input  wire logic               ccr_imask_i,
  output logic                    irq_start_o,
  output logic                    cpu_reset_o,
  // Reset pin.
  input  wire logic               reset_pin_n_i,
  // Mode and clock control.
  output logic      [2:0]         mode_o,
  output logic                    osc_enable_o,
  output logic                    cpu_clk_en_o,
  output logic                    periph_clk_en_o,
  output logic                    pwm_halt_o,
  output logic                    cpu_clk_sub_o,
  output logic      [3:0]         sub_clk_div_o,
  output logic      [4:0]         noise_div_o
);

  initial begin
    if (IRQ_N < 1 || IRQ_N > 8 || SETTLE_BASE < 2 || SETTLE_BASE > 8192) begin
      $error("Unsupported parameter value");
    end
  end

  // Register fields.
  logic                  standby_select_bit;
  logic [2:0]            settle_wait_sel;
  logic                  low_speed_select_bit;
  logic                  noise_sample_rate_select;
  logic                  direct_transfer_bit;
  logic                  medium_speed_select_bit;
  logic                  sub_clock_div_hi;
  logic                  sub_clock_div_lo;

  pdmc_pkg::pdmc_mode_t  state;
  pdmc_pkg::pdmc_mode_t  next_state;
  pdmc_pkg::pdmc_mode_t  sleep_target;
  logic                  next_irq_start;
  logic                  pin_level;

  // Bus decode.
  wire        bus_req   = wb_cyc_i && wb_stb_i;
  wire        hit_reg1  = (wb_adr_i == pdmc_pkg::REG1_ADR);
  wire        hit_reg2  = (wb_adr_i == pdmc_pkg::REG2_ADR);
  wire        bus_write = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire        wr_reg1   = bus_write && hit_reg1;
  wire        wr_reg2   = bus_write && hit_reg2;
  wire [7:0]  reg1_view = {standby_select_bit, settle_wait_sel, low_speed_select_bit,
                           pdmc_pkg::REG1_RSVD};
  wire [7:0]  reg2_view = {pdmc_pkg::REG2_RSVD, noise_sample_rate_select, direct_transfer_bit,
                           medium_speed_select_bit, sub_clock_div_hi, sub_clock_div_lo};
  wire [7:0]  read_byte = hit_reg1 ? reg1_view : (hit_reg2 ? reg2_view : 8'h00);

  // Interrupt qualification.
  wire [IRQ_N-1:0] irq_live  = irq_req_i & irq_en_i;
  wire             wake_any  = (|irq_live) && !ccr_imask_i;
  wire             wake_deep = (|(irq_live & DEEP_WAKE[IRQ_N-1:0])) && !ccr_imask_i;
  wire             pin_reset = !pin_level;
  wire             in_active = (state == pdmc_pkg::M_ACT_HI) || (state == pdmc_pkg::M_ACT_MED);
  wire             in_sub    = (state == pdmc_pkg::M_SUBACT);

  // Settling wait length; any code with the top bit set gives the longest wait.
  wire [1:0]                       wait_shift  = settle_wait_sel[2] ? 2'h3 : settle_wait_sel[1:0];
  wire [pdmc_pkg::SETTLE_W-1:0]    base_cycles = pdmc_pkg::SETTLE_W'(SETTLE_BASE);
  wire [pdmc_pkg::SETTLE_W-1:0]    wait_cycles = settle_wait_sel[2] ? (base_cycles << 4)
                                                                     : (base_cycles << wait_shift);
  wire                             settle_load;
  wire                             settle_busy;
  wire                             settle_done;

  assign settle_load = (state != pdmc_pkg::M_SETTLE) && (next_state == pdmc_pkg::M_SETTLE);

  pdmc_pin_sync #(
    .IDLE (1'b1)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (reset_pin_n_i),
    .level_o (pin_level)
  );

  pdmc_settle_timer #(
    .W (pdmc_pkg::SETTLE_W)
  ) u_settle (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (settle_load),
    .cycles_i (wait_cycles),
    .busy_o   (settle_busy),
    .done_o   (settle_done)
  );

  // Register file.
  always_ff @(posedge clk_i) begin
    if (rst_i || pin_reset) begin
      {standby_select_bit, settle_wait_sel, low_speed_select_bit} <= pdmc_pkg::REG1_RESET[7:3];
      {noise_sample_rate_select, direct_transfer_bit, medium_speed_select_bit}
        <= pdmc_pkg::REG2_RESET[4:2];
      {sub_clock_div_hi, sub_clock_div_lo} <= pdmc_pkg::REG2_RESET[1:0];
    end else begin
      if (wr_reg1) begin
        standby_select_bit   <= wb_dat_i[pdmc_pkg::STBY_POS];
        settle_wait_sel      <= wb_dat_i[pdmc_pkg::WAIT_HI:pdmc_pkg::WAIT_LO];
        low_speed_select_bit <= wb_dat_i[pdmc_pkg::LSPD_POS];
      end
      if (wr_reg2) begin
        noise_sample_rate_select <= wb_dat_i[pdmc_pkg::NSEL_POS];
        direct_transfer_bit      <= wb_dat_i[pdmc_pkg::DTR_POS];
        medium_speed_select_bit  <= wb_dat_i[pdmc_pkg::MSPD_POS];
      end
      if (wr_reg2 && !in_sub) begin
        sub_clock_div_hi <= wb_dat_i[pdmc_pkg::SDIV_HI];
        sub_clock_div_lo <= wb_dat_i[pdmc_pkg::SDIV_LO];
      end
    end
  end

  // Bus answer one cycle after the request; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= {24'h000000, read_byte};
    end
  end

  wire pdmc_pkg::pdmc_mode_t wake_speed = medium_speed_select_bit ? pdmc_pkg::M_ACT_MED
                                                                  : pdmc_pkg::M_ACT_HI;

  // Mode chosen by SLEEP, from the register values and timer bit of this very cycle.
  always_comb begin
    sleep_target = state;
    if (in_active) begin
      if (direct_transfer_bit && standby_select_bit && timer_watch_select_i && low_speed_select_bit) begin
        sleep_target = pdmc_pkg::M_SUBACT;
      end else if (direct_transfer_bit && !standby_select_bit && !low_speed_select_bit &&
                   (state == pdmc_pkg::M_ACT_HI) && medium_speed_select_bit) begin
        sleep_target = pdmc_pkg::M_ACT_MED;
      end else if (direct_transfer_bit && !standby_select_bit && !low_speed_select_bit &&
                   (state == pdmc_pkg::M_ACT_MED) && !medium_speed_select_bit) begin
        sleep_target = pdmc_pkg::M_ACT_HI;
      end else if (!standby_select_bit && !low_speed_select_bit) begin
        sleep_target = pdmc_pkg::M_SLEEP;
      end else if (standby_select_bit && timer_watch_select_i) begin
        sleep_target = pdmc_pkg::M_WATCH;
      end else if (standby_select_bit && !low_speed_select_bit) begin
        sleep_target = pdmc_pkg::M_STANDBY;
      end
    end else if (in_sub) begin
      if (direct_transfer_bit && standby_select_bit && timer_watch_select_i && !low_speed_select_bit) begin
        sleep_target = wake_speed;
      end else if (!standby_select_bit) begin
        sleep_target = pdmc_pkg::M_SUBSLEEP;
      end else begin
        sleep_target = pdmc_pkg::M_WATCH;
      end
    end
  end

  // Mode sequencing.
  always_comb begin
    next_state     = state;
    next_irq_start = 1'b0;
    case (state)
      pdmc_pkg::M_ACT_HI, pdmc_pkg::M_ACT_MED, pdmc_pkg::M_SUBACT: begin
        if (sleep_exec_i) begin
          next_state = sleep_target;
        end
      end
      pdmc_pkg::M_SLEEP: begin
        if (wake_any) begin
          next_state     = wake_speed;
          next_irq_start = 1'b1;
        end
      end
      pdmc_pkg::M_STANDBY: begin
        if (wake_deep) begin
          next_state = pdmc_pkg::M_SETTLE;
        end
      end
      pdmc_pkg::M_WATCH: begin
        if (wake_deep && low_speed_select_bit) begin
          next_state     = pdmc_pkg::M_SUBACT;
          next_irq_start = 1'b1;
        end else if (wake_deep) begin
          next_state = pdmc_pkg::M_SETTLE;
        end
      end
      pdmc_pkg::M_SETTLE: begin
        if (settle_done) begin
          next_state     = wake_speed;
          next_irq_start = 1'b1;
        end
      end
      pdmc_pkg::M_SUBSLEEP: begin
        if (wake_deep) begin
          next_state     = pdmc_pkg::M_SUBACT;
          next_irq_start = 1'b1;
        end
      end
      default: begin
        next_state = pdmc_pkg::M_ACT_HI;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || pin_reset) begin
      state       <= pdmc_pkg::M_ACT_HI;
      irq_start_o <= 1'b0;
      cpu_reset_o <= !rst_i;
    end else begin
      state       <= next_state;
      irq_start_o <= next_irq_start;
      cpu_reset_o <= 1'b0;
    end
  end

  // Clock gating and clock selection.
  assign mode_o          = state;
  assign cpu_clk_en_o    = in_active || in_sub;
  assign periph_clk_en_o = in_active || in_sub || (state == pdmc_pkg::M_SLEEP) ||
                           (state == pdmc_pkg::M_SUBSLEEP);
  assign pwm_halt_o      = !in_active;
  assign osc_enable_o    = in_active || (state == pdmc_pkg::M_SLEEP) || (state == pdmc_pkg::M_SETTLE);
  assign cpu_clk_sub_o   = in_sub || (state == pdmc_pkg::M_SUBSLEEP) ||
                           ((state == pdmc_pkg::M_WATCH) && low_speed_select_bit);
  assign sub_clk_div_o   = sub_clock_div_hi ? pdmc_pkg::SUB_DIV_2
                         : (sub_clock_div_lo ? pdmc_pkg::SUB_DIV_4 : pdmc_pkg::SUB_DIV_8);
  assign noise_div_o     = noise_sample_rate_select ? pdmc_pkg::NOISE_4 : pdmc_pkg::NOISE_16;

  // Checks on the behaviour above.
  property p_sleep_entry;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      (in_active && sleep_exec_i && !direct_transfer_bit && !standby_select_bit && !low_speed_select_bit)
        |=> (state == pdmc_pkg::M_SLEEP);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not entered");

  property p_subsleep_entry;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      (in_sub && sleep_exec_i && !standby_select_bit) |=> (state == pdmc_pkg::M_SUBSLEEP);
  endproperty
  a_subsleep_entry: assert property (p_subsleep_entry) else $error("Subsleep not entered");

  property p_standby_entry;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      (in_active && sleep_exec_i && !direct_transfer_bit && standby_select_bit && !low_speed_select_bit &&
       !timer_watch_select_i) |=> (state == pdmc_pkg::M_STANDBY) && !osc_enable_o;
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("Standby not entered");

  property p_settle_hold;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      (state == pdmc_pkg::M_SETTLE) |-> !cpu_clk_en_o && osc_enable_o && (settle_busy || settle_done);
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("Clock released during settle");

  property p_wait_len;
    @(posedge clk_i) disable iff (rst_i)
      int'(wait_cycles) == (settle_wait_sel[2] ? SETTLE_BASE * 16 : SETTLE_BASE << settle_wait_sel[1:0]);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("Wrong long settle wait");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (!hit_reg1 || (wb_dat_o[2:0] == 3'h7)) && (!hit_reg2 || (wb_dat_o[7:5] == 3'h7));
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not one");

  property p_div_frozen;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      (in_sub && wr_reg2) |=> $stable(sub_clk_div_o);
  endproperty
  a_div_frozen: assert property (p_div_frozen) else $error("Divider changed in subactive");

  property p_sleep_wake;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      ((state == pdmc_pkg::M_SLEEP) && wake_any) |=> irq_start_o && in_active &&
        ((state == pdmc_pkg::M_ACT_MED) == $past(medium_speed_select_bit));
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("Sleep wake wrong");

  property p_masked;
    @(posedge clk_i) disable iff (rst_i || pin_reset)
      ((state == pdmc_pkg::M_SLEEP) && ccr_imask_i) |=> (state == pdmc_pkg::M_SLEEP);
  endproperty
  a_masked: assert property (p_masked) else $error("Masked interrupt ended sleep");

  property p_pin_reset;
    @(posedge clk_i) disable iff (rst_i)
      $fell(pin_level) |=> cpu_reset_o && (state == pdmc_pkg::M_ACT_HI);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("Pin reset not taken");

  c_sleep_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
    (state == pdmc_pkg::M_SLEEP) ##1 irq_start_o);
  c_settle_done: cover property (@(posedge clk_i) disable iff (rst_i) settle_done);
  c_direct_sub:  cover property (@(posedge clk_i) disable iff (rst_i)
    in_active ##1 (state == pdmc_pkg::M_SUBACT));

endmodule : pdmc_top

//--- tb/pdmc_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the power-down mode controller.
`timescale 1ns/1ps
module pdmc_cpu_model (
  // Clock.
  input  wire logic       clk_i,
  // Exception start from the controller.
  input  wire logic       irq_start_i,
  // SLEEP, timer-watch bit and interrupts.
  output logic            sleep_exec_o,
  output logic            tw_sel_o,
  output logic [7:0]      irq_req_o,
  output logic [7:0]      irq_en_o,
  output logic            imask_o
);
  initial begin
    sleep_exec_o = 1'b0;
    tw_sel_o     = 1'b0;
    irq_req_o    = 8'h00;
    irq_en_o     = 8'hFF;
    imask_o      = 1'b0;
  end
  // A request is withdrawn once its exception handling has started, as a real controller acknowledges it.
  always @(posedge clk_i) begin
    if (irq_start_i) begin
      irq_req_o <= 8'h00;
    end
  end
  // SLEEP lasts one cycle; the timer-watch bit is set up with it and then held.
  task sleep_op(input logic tw);
    @(posedge clk_i);
    tw_sel_o     <= tw;
    sleep_exec_o <= 1'b1;
    @(posedge clk_i);
    sleep_exec_o <= 1'b0;
  endtask : sleep_op
  task raise(input logic [7:0] r, input logic [7:0] en, input logic m);
    @(posedge clk_i);
    irq_en_o  <= en;
    imask_o   <= m;
    irq_req_o <= r;
  endtask : raise
endmodule : pdmc_cpu_model

//--- tb/test_power_down_mode_controller.sv
// Self-checking testbench of the power-down mode controller.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module test_power_down_mode_controller;
  localparam logic [17:0] A1 = pdmc_pkg::REG1_ADR;
  localparam logic [17:0] A2 = pdmc_pkg::REG2_ADR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic        pin_n = 1'b1;
  logic        sx, tw, imask, irq_start_o, cpu_reset_o, osc_o, cpu_clk_en_o, per_o, pwm_o, sub_o, wb_ack_o;
  logic [7:0]  irq, en;
  logic [31:0] wb_dat_o;
  logic [2:0]  mode_o;
  logic [3:0]  sub_clk_div_o;
  logic [4:0]  noise_div_o;
  int          fails = 0;
  int          n_tests = 0;
  int          n_start = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (irq_start_o === 1'b1) n_start++;
  pdmc_cpu_model cpu_u (.clk_i(clk), .irq_start_i(irq_start_o), .sleep_exec_o(sx), .tw_sel_o(tw),
    .irq_req_o(irq), .irq_en_o(en), .imask_o(imask));
  pdmc_top #(.SETTLE_BASE(4)) dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_exec_i(sx), .timer_watch_select_i(tw), .irq_req_i(irq), .irq_en_i(en), .ccr_imask_i(imask),
    .irq_start_o(irq_start_o), .cpu_reset_o(cpu_reset_o), .reset_pin_n_i(pin_n), .mode_o(mode_o),
    .osc_enable_o(osc_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(per_o), .pwm_halt_o(pwm_o),
    .cpu_clk_sub_o(sub_o), .sub_clk_div_o(sub_clk_div_o), .noise_div_o(noise_div_o));
  task give_verdict;
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [7:0] q);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      give_verdict();
    end else begin
      q = wb_dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      #1;
    end
  endtask : wb
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    `CHK("read", e, q)
  endtask : rdc
  task mchk(input logic [2:0] e);
    `CHK("mode", e, mode_o)
  endtask : mchk
  task sleep_chk(input logic t, input logic [2:0] e);
    cpu_u.sleep_op(t);
    #1;
    mchk(e);
  endtask : sleep_chk
  // Wake with an enabled source and time how long the CPU stays unclocked.
  task automatic wake_settle(input int n);
    int k;
    logic bad;
    k = 0;
    bad = 1'b0;
    cpu_u.raise(8'h01, 8'hFF, 1'b0);
    tick(1);
    while (mode_o !== 3'(pdmc_pkg::M_ACT_HI) && k < 200) begin
      if (cpu_clk_en_o !== 1'b0 || osc_o !== 1'b1) bad = 1'b1;
      tick(1);
      k++;
    end
    `CHK("clk_gate", 1'b0, bad)
    `CHK("settle", 1'b1, (k >= n && k <= n + 3))
  endtask : wake_settle
  initial begin
    logic [7:0] q;
    int s0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    rdc(A1, 8'h07);
    rdc(A2, 8'hE0);
    rdc(18'h00010, 8'h00);
    wr(A1, 8'h00);
    rdc(A1, 8'h07);
    // Fast sampling is legal here because the oscillator runs well above 10 MHz.
    wr(A2, 8'h10);
    rdc(A2, 8'hF0);
    `CHK("noise", 5'h04, noise_div_o)
    for (int i = 0; i < 4; i++) begin
      wr(A2, 8'(i));
      `CHK("div", (i == 0) ? 4'h8 : (i == 1) ? 4'h4 : 4'h2, sub_clk_div_o)
    end
    `CHK("noise", 5'h10, noise_div_o)
    wb(1'b1, A2, 8'h10, 4'h0, q);
    rdc(A2, 8'hE3);
    wr(A2, 8'h00);
    wr(A1, 8'h07);
    sleep_chk(1'b0, pdmc_pkg::M_SLEEP);
    `CHK("halt", 4'b1011, {pwm_o, cpu_clk_en_o, per_o, osc_o})
    s0 = n_start;
    cpu_u.raise(8'h10, 8'hFF, 1'b1);
    tick(5);
    mchk(pdmc_pkg::M_SLEEP);
    cpu_u.raise(8'h10, 8'hEF, 1'b0);
    tick(5);
    mchk(pdmc_pkg::M_SLEEP);
    cpu_u.raise(8'h10, 8'hFF, 1'b0);
    tick(3);
    mchk(pdmc_pkg::M_ACT_HI);
    `CHK("starts", s0 + 1, n_start)
    wr(A2, 8'h04);
    sleep_chk(1'b0, pdmc_pkg::M_SLEEP);
    cpu_u.raise(8'h01, 8'hFF, 1'b0);
    tick(3);
    mchk(pdmc_pkg::M_ACT_MED);
    wr(A2, 8'h08);
    sleep_chk(1'b0, pdmc_pkg::M_ACT_HI);
    wr(A2, 8'h0C);
    sleep_chk(1'b0, pdmc_pkg::M_ACT_MED);
    wr(A1, 8'h8F);
    sleep_chk(1'b1, pdmc_pkg::M_SUBACT);
    wr(A2, 8'h09);
    rdc(A2, 8'hE8);
    `CHK("div", 4'h8, sub_clk_div_o)
    wr(A1, 8'h87);
    sleep_chk(1'b1, pdmc_pkg::M_ACT_HI);
    wr(A1, 8'h8F);
    sleep_chk(1'b1, pdmc_pkg::M_SUBACT);
    wr(A2, 8'h0C);
    wr(A1, 8'h87);
    sleep_chk(1'b1, pdmc_pkg::M_ACT_MED);
    wr(A2, 8'h00);
    wr(A1, 8'h8F);
    sleep_chk(1'b1, pdmc_pkg::M_WATCH);
    `CHK("subclk", 1'b1, sub_o)
    cpu_u.raise(8'h01, 8'hFF, 1'b0);
    tick(3);
    mchk(pdmc_pkg::M_SUBACT);
    wr(A1, 8'h0F);
    sleep_chk(1'b1, pdmc_pkg::M_SUBSLEEP);
    cpu_u.raise(8'h01, 8'hFF, 1'b0);
    tick(3);
    mchk(pdmc_pkg::M_SUBACT);
    wr(A1, 8'h87);
    sleep_chk(1'b1, pdmc_pkg::M_WATCH);
    `CHK("subclk", 1'b0, sub_o)
    wake_settle(4);
    // Shortened base count in simulation; real software sizes the wait for at least 10 ms.
    for (int c = 0; c < 8; c++) begin
      wr(A1, {1'b1, 3'(c), 4'h7});
      sleep_chk(1'b0, pdmc_pkg::M_STANDBY);
      wake_settle((c >= 4) ? 64 : (4 << c));
    end
    wr(A1, 8'h77);
    sleep_chk(1'b0, pdmc_pkg::M_SLEEP);
    @(posedge clk);
    pin_n <= 1'b0;
    tick(6);
    `CHK("cpu_reset", 1'b1, cpu_reset_o)
    mchk(pdmc_pkg::M_ACT_HI);
    @(posedge clk);
    pin_n <= 1'b1;
    tick(6);
    `CHK("cpu_reset", 1'b0, cpu_reset_o)
    rdc(A1, 8'h07);
    give_verdict();
  end
endmodule : test_power_down_mode_controller
